// >>> shared/vpls_map.vh
// Field layout, codes, masks and access widths of the virtual PHY special control/status register
`ifndef VPLS_MAP_VH
`define VPLS_MAP_VH

`define VPLS_REG_W           32
`define VPLS_SER_W           16
`define VPLS_BIT_MODE2       15
`define VPLS_BIT_LOOPBACK    14
`define VPLS_BIT_MODE_HI     9
`define VPLS_BIT_MODE_LO     8
`define VPLS_BIT_COLL_TEST   7
`define VPLS_BIT_REFCLK_DIR  6
`define VPLS_BIT_REFCLK_DRV  5
`define VPLS_BIT_SPD_HI      4
`define VPLS_BIT_SPD_LO      2

`define VPLS_SPD_10_HALF     3'h1
`define VPLS_SPD_100_HALF    3'h2
`define VPLS_SPD_10_FULL     3'h5
`define VPLS_SPD_100_FULL    3'h6

`define VPLS_MODE_RMII_MAC   3'h2
`define VPLS_MODE_RMII_PHY   3'h3
`define VPLS_MODE_RESERVED   3'h0

`define VPLS_WR_MASK         32'h0000_40E0
`define VPLS_RD_MASK         32'h0000_C3FC
`define VPLS_CTRL_RESET      1'b0
`define VPLS_SPD_RESET       3'h0

`endif

// >>> core/vpls_spd_code.v
// Encoder from speed and duplex selections to the three-bit speed/duplex code
`timescale 1ns/1ps
`include "vpls_map.vh"

module vpls_spd_code (
  input  wire       i_speed_100,
  input  wire       i_full_duplex,
  output reg  [2:0] o_code
);

  always @* begin
    case ({i_full_duplex, i_speed_100})
      2'h0:    o_code = `VPLS_SPD_10_HALF;
      2'h1:    o_code = `VPLS_SPD_100_HALF;
      2'h2:    o_code = `VPLS_SPD_10_FULL;
      default: o_code = `VPLS_SPD_100_FULL;
    endcase
  end

endmodule

// >>> core/vpls_status_reg.v
// Virtual PHY special control/status register for switch port 0
// Notes on behaviour
// - Speed/duplex is a read-only code in bits 4:2; 1,2,5,6 valid.
// - Autoneg enabled: code from negotiation; else from speed-low and duplex bits.
// - Register is 32 bits, top 16 zero; serial access sees low 16 bits.
// - Mode, clock direction and drive strength defaults come from power-up straps.
// - Sticky bits reset only by i_rst, or by reset-control virtual PHY reset when soft reset set.
// - Port mode code: 010 RMII MAC, 011 RMII PHY, others reserved.
// - Clock direction bit zero makes reference clock input, one output.
`timescale 1ns/1ps
`include "vpls_map.vh"

module vpls_status_reg (
  input  wire        i_clock,
  input  wire        i_rst,
  input  wire        i_vphy_reset,
  input  wire        i_vphy_soft_reset_bit,
  input  wire [2:0]  i_port0_mode_strap,
  input  wire        i_port0_refclk_direction_strap,
  input  wire        i_port0_refclk_drive_strap,
  input  wire        i_vphy_autoneg_enable,
  input  wire        i_vphy_speed_select_low,
  input  wire        i_select_a,
  input  wire        i_an_speed_100,
  input  wire        i_an_full_duplex,
  input  wire        i_wr_en,
  input  wire [31:0] i_wr_data,
  input  wire        i_serial_access,
  output reg  [31:0] o_rd_data,
  output reg  [2:0]  o_port_mode,
  output reg         o_refclk_out_en,
  output reg         o_refclk_drive_high,
  output reg         o_loopback,
  output reg         o_coll_test
);

  // Writable and readable bit sets of the 32-bit image
  localparam [31:0] WR_MASK = `VPLS_WR_MASK;
  localparam [31:0] RD_MASK = `VPLS_RD_MASK;

  reg         loopback_r;
  reg         loopback_nxt;
  reg         coll_test_r;
  reg         coll_test_nxt;
  reg         refclk_dir_r;
  reg         refclk_dir_nxt;
  reg         refclk_drv_r;
  reg         refclk_drv_nxt;
  reg  [2:0]  mode_r;
  reg  [2:0]  mode_nxt;
  reg  [2:0]  spd_code_r;
  reg  [2:0]  spd_code_nxt;
  reg  [31:0] rd_image;
  wire        speed_100;
  wire        full_duplex;
  wire [2:0]  spd_code;
  wire        sticky_rst;
  wire        ctrl_rst;
  wire        wr_take;
  wire        mode_strap_ok;
  wire [2:0]  mode_strap_clean;
  wire [31:0] wr_bits;
  wire [31:0] rd_nxt;
  genvar      gi;

  // Only i_rst or a reset-control virtual PHY reset with soft reset set reloads sticky bits
  assign sticky_rst = i_vphy_reset & i_vphy_soft_reset_bit;
  assign ctrl_rst   = i_rst | i_vphy_reset;
  // A write in a reset cycle is dropped: reset always wins
  assign wr_take    = i_wr_en & ~ctrl_rst;

  // Reserved strap codes are stored as 000 so the mode never shows a half-valid code
  assign mode_strap_ok    = (i_port0_mode_strap == `VPLS_MODE_RMII_MAC) ||
                            (i_port0_mode_strap == `VPLS_MODE_RMII_PHY);
  assign mode_strap_clean = mode_strap_ok ? i_port0_mode_strap : `VPLS_MODE_RESERVED;

  assign speed_100   = i_vphy_autoneg_enable ? i_an_speed_100 : i_vphy_speed_select_low;
  assign full_duplex = i_vphy_autoneg_enable ? i_an_full_duplex : i_select_a;

  vpls_spd_code vpls_spd_code_inst (
    .i_speed_100   (speed_100),
    .i_full_duplex (full_duplex),
    .o_code        (spd_code)
  );

  // Per-bit masks: read-only and pad bits drop writes and read back only their own fields
  generate
    for (gi = 0; gi < `VPLS_REG_W; gi = gi + 1) begin : g_bit
      assign wr_bits[gi] = i_wr_data[gi] & WR_MASK[gi];
      assign rd_nxt[gi]  = rd_image[gi] & RD_MASK[gi];
    end
  endgenerate

  // Mode is fixed by the straps at reset; no write or virtual PHY reset moves it
  always @* begin
    mode_nxt = mode_r;
    if (i_rst) begin
      mode_nxt = mode_strap_clean;
    end
  end

  // Sticky bits: a plain virtual PHY reset leaves them, so the clock setup survives it
  always @* begin
    refclk_dir_nxt = refclk_dir_r;
    refclk_drv_nxt = refclk_drv_r;
    if (i_rst || sticky_rst) begin
      refclk_dir_nxt = i_port0_refclk_direction_strap;
      refclk_drv_nxt = i_port0_refclk_drive_strap;
    end else if (wr_take) begin
      refclk_dir_nxt = wr_bits[`VPLS_BIT_REFCLK_DIR];
      refclk_drv_nxt = wr_bits[`VPLS_BIT_REFCLK_DRV];
    end
  end

  always @* begin
    loopback_nxt  = loopback_r;
    coll_test_nxt = coll_test_r;
    if (ctrl_rst) begin
      loopback_nxt  = `VPLS_CTRL_RESET;
      coll_test_nxt = `VPLS_CTRL_RESET;
    end else if (wr_take) begin
      loopback_nxt  = wr_bits[`VPLS_BIT_LOOPBACK];
      coll_test_nxt = wr_bits[`VPLS_BIT_COLL_TEST];
    end
  end

  // The code is taken again every cycle, so it trails a link change by one edge, and o_rd_data trails it by two
  always @* begin
    spd_code_nxt = spd_code;
    if (ctrl_rst) begin
      spd_code_nxt = `VPLS_SPD_RESET;
    end
  end

  // Straps enter through clocked logic, so no port value reaches a register asynchronously
  always @(posedge i_clock) begin
    mode_r <= mode_nxt;
  end

  always @(posedge i_clock) begin
    refclk_dir_r <= refclk_dir_nxt;
  end

  always @(posedge i_clock) begin
    refclk_drv_r <= refclk_drv_nxt;
  end

  always @(posedge i_clock) begin
    loopback_r <= loopback_nxt;
  end

  always @(posedge i_clock) begin
    coll_test_r <= coll_test_nxt;
  end

  always @(posedge i_clock) begin
    spd_code_r <= spd_code_nxt;
  end

  always @* begin
    rd_image = 32'h0000_0000;
    rd_image[`VPLS_BIT_MODE2] = mode_r[2];
    rd_image[`VPLS_BIT_LOOPBACK] = loopback_r;
    rd_image[`VPLS_BIT_MODE_HI:`VPLS_BIT_MODE_LO] = mode_r[1:0];
    rd_image[`VPLS_BIT_COLL_TEST] = coll_test_r;
    rd_image[`VPLS_BIT_REFCLK_DIR] = refclk_dir_r;
    rd_image[`VPLS_BIT_REFCLK_DRV] = refclk_drv_r;
    rd_image[`VPLS_BIT_SPD_HI:`VPLS_BIT_SPD_LO] = spd_code_r;
    if (i_serial_access) begin
      rd_image[`VPLS_REG_W-1:`VPLS_SER_W] = 16'h0000;
    end
  end

  always @(posedge i_clock) begin
    if (i_rst) begin
      o_rd_data <= 32'h0000_0000;
    end else begin
      o_rd_data <= rd_nxt;
    end
  end

  always @(posedge i_clock) begin
    if (i_rst) begin
      o_port_mode <= 3'h0;
    end else begin
      o_port_mode <= mode_r;
    end
  end

  // One drives the reference clock pin out; zero leaves it an input
  always @(posedge i_clock) begin
    if (i_rst) begin
      o_refclk_out_en <= 1'b0;
    end else begin
      o_refclk_out_en <= refclk_dir_r;
    end
  end

  always @(posedge i_clock) begin
    if (i_rst) begin
      o_refclk_drive_high <= 1'b0;
    end else begin
      o_refclk_drive_high <= refclk_drv_r;
    end
  end

  always @(posedge i_clock) begin
    if (i_rst) begin
      o_loopback <= 1'b0;
    end else begin
      o_loopback <= loopback_r;
    end
  end

  always @(posedge i_clock) begin
    if (i_rst) begin
      o_coll_test <= 1'b0;
    end else begin
      o_coll_test <= coll_test_r;
    end
  end

endmodule

// >>> tb/vpls_status_reg_monitor.sv
// Port checker for the virtual PHY special control/status register
`timescale 1ns/1ps
module vpls_mon (
  input wire        i_clock,
  input wire        i_rst,
  input wire        i_vphy_reset,
  input wire        i_vphy_soft_reset_bit,
  input wire        i_wr_en,
  input wire        i_port0_refclk_direction_strap,
  input wire        i_vphy_autoneg_enable,
  input wire        i_select_a,
  input wire        i_vphy_speed_select_low,
  input wire        i_an_speed_100,
  input wire        i_an_full_duplex,
  input wire [31:0] i_wr_data,
  input wire [31:0] o_rd_data,
  input wire [2:0]  o_port_mode,
  input wire        o_refclk_out_en,
  input wire        o_loopback,
  input wire        o_coll_test
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (i_rst);
  // Two-edge history of any reset, so pipeline checks skip refilling cycles
  logic [1:0] hist_r = 2'h3;
  always @(posedge i_clock) hist_r <= {hist_r[0], i_rst | i_vphy_reset};
  wire calm = hist_r == 2'h0;
  res_pad_a: assert property (o_rd_data[31:16] == 16'h0 && o_rd_data[1:0] == 2'h0)
    else $error("reserved bits not zero");
  spd_an_a: assert property (calm && $past(i_vphy_autoneg_enable, 2) |-> o_rd_data[4:2] ==
    {$past(i_an_full_duplex, 2), $past(i_an_speed_100, 2), !$past(i_an_speed_100, 2)})
    else $error("negotiated speed code wrong");
  spd_man_a: assert property (calm && !$past(i_vphy_autoneg_enable, 2) |-> o_rd_data[4:2] ==
    {$past(i_select_a, 2), $past(i_vphy_speed_select_low, 2), !$past(i_vphy_speed_select_low, 2)})
    else $error("manual speed code wrong");
  wr_ctrl_a: assert property (i_wr_en && !i_vphy_reset |-> ##2 o_loopback == $past(i_wr_data[14], 2)
    && o_coll_test == $past(i_wr_data[7], 2)) else $error("control write lost");
  mirror_bits_a: assert property (o_rd_data[14] == o_loopback && o_rd_data[7] == o_coll_test
    && o_rd_data[6] == o_refclk_out_en) else $error("image differs from outputs");
  mode_code_a: assert property (o_port_mode inside {3'h0, 3'h2, 3'h3})
    else $error("mode code reserved");
  sticky_load_a: assert property (i_vphy_reset && i_vphy_soft_reset_bit |-> ##2
    o_refclk_out_en == $past(i_port0_refclk_direction_strap, 2)) else $error("strap not reloaded");
  sticky_keep_a: assert property (i_vphy_reset && !i_vphy_soft_reset_bit && !i_wr_en
    && !$past(i_wr_en) |=> ##1 $stable(o_refclk_out_en)) else $error("sticky bit lost");
  cover property (calm && i_vphy_autoneg_enable);
  cover property (i_vphy_reset && i_vphy_soft_reset_bit);
  cover property (i_wr_en && i_wr_data[14]);
endmodule
bind vpls_status_reg vpls_mon vpls_mon_inst (
  .i_clock                        (i_clock),
  .i_rst                          (i_rst),
  .i_vphy_reset                   (i_vphy_reset),
  .i_vphy_soft_reset_bit          (i_vphy_soft_reset_bit),
  .i_wr_en                        (i_wr_en),
  .i_port0_refclk_direction_strap (i_port0_refclk_direction_strap),
  .i_vphy_autoneg_enable          (i_vphy_autoneg_enable),
  .i_select_a                     (i_select_a),
  .i_vphy_speed_select_low        (i_vphy_speed_select_low),
  .i_an_speed_100                 (i_an_speed_100),
  .i_an_full_duplex               (i_an_full_duplex),
  .i_wr_data                      (i_wr_data),
  .o_rd_data                      (o_rd_data),
  .o_port_mode                    (o_port_mode),
  .o_refclk_out_en                (o_refclk_out_en),
  .o_loopback                     (o_loopback),
  .o_coll_test                    (o_coll_test)
);

// >>> tb/vpls_host_model.sv
// Management host model seeing the serial view of the register
`timescale 1ns/1ps
module vpls_host (
  input  wire        i_clock,
  input  wire [31:0] i_rd_data,
  output reg         o_serial_access = 1'b1,
  output reg  [15:0] o_frame
);
  // Serial frames carry only the low half; the pad never reaches the wire
  always @(posedge i_clock) o_frame <= i_rd_data[15:0];
endmodule

// >>> tb/vpls_status_reg_test.sv
// Self-checking bench for the virtual PHY special control/status register
`timescale 1ns/1ps
module vpls_status_reg_test;
  reg i_clock = 0, i_rst = 1, i_vphy_reset = 0, i_vphy_soft_reset_bit = 0, i_wr_en = 0;
  reg i_vphy_autoneg_enable = 0, i_vphy_speed_select_low = 0, i_select_a = 0;
  reg i_an_speed_100 = 0, i_an_full_duplex = 0, i_port0_refclk_direction_strap = 1;
  reg i_port0_refclk_drive_strap = 0;
  reg [2:0] i_port0_mode_strap = 3'h2;
  reg [31:0] i_wr_data = 32'h0;
  wire i_serial_access, o_refclk_out_en, o_refclk_drive_high, o_loopback, o_coll_test;
  wire [31:0] o_rd_data;
  wire [2:0] o_port_mode;
  wire [15:0] frame;
  int n_errors = 0, checked = 0;
  // Row: autoneg, speed low, duplex, neg 100, neg full, expected code
  reg [7:0] rows [0:7] = '{8'h19, 8'h4A, 8'h35, 8'h66, 8'hE1, 8'hB2, 8'hCD, 8'h9E};
  vpls_status_reg vpls_status_reg_inst (
    .i_clock                        (i_clock),
    .i_rst                          (i_rst),
    .i_vphy_reset                   (i_vphy_reset),
    .i_vphy_soft_reset_bit          (i_vphy_soft_reset_bit),
    .i_port0_mode_strap             (i_port0_mode_strap),
    .i_port0_refclk_direction_strap (i_port0_refclk_direction_strap),
    .i_port0_refclk_drive_strap     (i_port0_refclk_drive_strap),
    .i_vphy_autoneg_enable          (i_vphy_autoneg_enable),
    .i_vphy_speed_select_low        (i_vphy_speed_select_low),
    .i_select_a                     (i_select_a),
    .i_an_speed_100                 (i_an_speed_100),
    .i_an_full_duplex               (i_an_full_duplex),
    .i_wr_en                        (i_wr_en),
    .i_wr_data                      (i_wr_data),
    .i_serial_access                (i_serial_access),
    .o_rd_data                      (o_rd_data),
    .o_port_mode                    (o_port_mode),
    .o_refclk_out_en                (o_refclk_out_en),
    .o_refclk_drive_high            (o_refclk_drive_high),
    .o_loopback                     (o_loopback),
    .o_coll_test                    (o_coll_test)
  );
  vpls_host vpls_host_inst (
    .i_clock         (i_clock),
    .i_rd_data       (o_rd_data),
    .o_serial_access (i_serial_access),
    .o_frame         (frame)
  );
  always #25 i_clock = ~i_clock;
  task chk(input logic [31:0] s, e);
    checked = checked + 1;
    if (s !== e) begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED %0t value mismatch", $time);
    end
  endtask
  task conclude;
    if (n_errors == 0 && checked > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task edges(input int n);
    repeat (n) @(posedge i_clock);
  endtask
  initial begin
    #20000;
    n_errors = n_errors + 1;
    conclude;
  end
  initial begin
    edges(3);
    i_rst <= 0;
    edges(2);
    @(negedge i_clock) chk({o_port_mode, o_rd_data[15], o_rd_data[9:8], o_refclk_out_en,
      o_rd_data[6], o_refclk_drive_high, o_rd_data[5]}, 10'h12C);
    for (int i = 0; i < 8; i++) begin
      @(posedge i_clock) {i_vphy_autoneg_enable, i_vphy_speed_select_low, i_select_a,
        i_an_speed_100, i_an_full_duplex} <= rows[i][7:3];
      edges(3);
      @(negedge i_clock) chk({o_rd_data[31:16], frame[4:2]}, rows[i][2:0]);
    end
    // Back-to-back writes; read-only and pad bits must not move
    @(posedge i_clock) {i_wr_en, i_wr_data} <= {1'b1, 32'hFFFF_FFFF};
    @(posedge i_clock) i_wr_data <= 32'h0000_4000;
    @(posedge i_clock) i_wr_en <= 0;
    edges(2);
    @(negedge i_clock) chk({o_rd_data[31:16], o_rd_data[1:0], o_loopback, o_coll_test,
      o_refclk_out_en, o_refclk_drive_high, o_rd_data[4:2]}, 32'h46);
    for (int k = 0; k < 2; k++) begin
      @(posedge i_clock) {i_vphy_reset, i_vphy_soft_reset_bit} <= {1'b1, k[0]};
      @(posedge i_clock) {i_vphy_reset, i_vphy_soft_reset_bit} <= 2'h0;
      edges(3);
      @(negedge i_clock) chk({o_refclk_out_en, o_loopback}, {k[0], 1'b0});
    end
    @(posedge i_clock) {i_rst, i_port0_mode_strap} <= {1'b1, 3'h5};
    edges(3);
    i_rst <= 0;
    edges(2);
    @(negedge i_clock) chk(o_port_mode, 3'h0);
    conclude;
  end
endmodule
